/* File: rtl/untranslated_sideband.v */
// manager-side driver for untranslated-transaction sideband signals
// assumes user requests are synchronous to CLK_SYS; receiver keeps its rules
//
// Operation
// - sideband driven only when property enabled
// - separate sideband copies for reads and writes
// - secure stream bit, default zero
// - stream identifier up to 32 bits, default zero
// - substream valid flag, default zero
// - substream identifier up to 20 bits
// - translated flag marks already translated requests
// - substream zeroed whenever its valid low
// - translated requests are never secure
// - translated requests carry no substream
// - non-secure stream forces protection bit one
// - unsupplied identifier bits tied low
// - substream and its valid travel together
`default_nettype none
`include "stream_sideband_defines.vh"
module untranslated_sideband (
  input  wire                    CLK_SYS,
  input  wire                    RESETN,
  input  wire                    CE,
  input  wire                    UT_ENABLE,
  // read request from user logic
  input  wire                    RD_REQ_VALID,
  output wire                    RD_REQ_READY,
  input  wire                    RD_REQ_SECURE,
  input  wire [`SB_SID_W-1:0]    RD_REQ_SID,
  input  wire                    RD_REQ_SSID_VALID,
  input  wire [`SB_SSID_W-1:0]   RD_REQ_SSID,
  input  wire                    RD_REQ_TRANSLATED,
  input  wire [`SB_PROT_W-1:0]   RD_REQ_PROT,
  // read address channel
  output wire                    ARVALID,
  input  wire                    ARREADY,
  output wire                    ARMMUSECSID,
  output wire [`SB_SID_W-1:0]    ARMMUSID,
  output wire                    ARMMUSSIDV,
  output wire [`SB_SSID_W-1:0]   ARMMUSSID,
  output wire                    ARMMUATST,
  output wire [`SB_PROT_W-1:0]   ARPROT,
  output wire                    RD_FIXED,
  // write request from user logic
  input  wire                    WR_REQ_VALID,
  output wire                    WR_REQ_READY,
  input  wire                    WR_REQ_SECURE,
  input  wire [`SB_SID_W-1:0]    WR_REQ_SID,
  input  wire                    WR_REQ_SSID_VALID,
  input  wire [`SB_SSID_W-1:0]   WR_REQ_SSID,
  input  wire                    WR_REQ_TRANSLATED,
  input  wire [`SB_PROT_W-1:0]   WR_REQ_PROT,
  // write address channel
  output wire                    AWVALID,
  input  wire                    AWREADY,
  output wire                    AWMMUSECSID,
  output wire [`SB_SID_W-1:0]    AWMMUSID,
  output wire                    AWMMUSSIDV,
  output wire [`SB_SSID_W-1:0]   AWMMUSSID,
  output wire                    AWMMUATST,
  output wire [`SB_PROT_W-1:0]   AWPROT,
  output wire                    WR_FIXED
);
  // the ready outputs are combinational so a request is never lost;
  // all channel outputs come from flops inside the channel module
  sideband_channel u_rd (
    .clk            (CLK_SYS),
    .resetn         (RESETN),
    .ce             (CE),
    .enable         (UT_ENABLE),
    .req_valid      (RD_REQ_VALID),
    .req_ready      (RD_REQ_READY),
    .req_secure     (RD_REQ_SECURE),
    .req_sid        (RD_REQ_SID),
    .req_ssid_valid (RD_REQ_SSID_VALID),
    .req_ssid       (RD_REQ_SSID),
    .req_translated (RD_REQ_TRANSLATED),
    .req_prot       (RD_REQ_PROT),
    .avalid         (ARVALID),
    .aready         (ARREADY),
    .secsid         (ARMMUSECSID),
    .sid            (ARMMUSID),
    .ssidv          (ARMMUSSIDV),
    .ssid           (ARMMUSSID),
    .atst           (ARMMUATST),
    .prot           (ARPROT),
    .fixed          (RD_FIXED)
  );

  sideband_channel u_wr (
    .clk            (CLK_SYS),
    .resetn         (RESETN),
    .ce             (CE),
    .enable         (UT_ENABLE),
    .req_valid      (WR_REQ_VALID),
    .req_ready      (WR_REQ_READY),
    .req_secure     (WR_REQ_SECURE),
    .req_sid        (WR_REQ_SID),
    .req_ssid_valid (WR_REQ_SSID_VALID),
    .req_ssid       (WR_REQ_SSID),
    .req_translated (WR_REQ_TRANSLATED),
    .req_prot       (WR_REQ_PROT),
    .avalid         (AWVALID),
    .aready         (AWREADY),
    .secsid         (AWMMUSECSID),
    .sid            (AWMMUSID),
    .ssidv          (AWMMUSSIDV),
    .ssid           (AWMMUSSID),
    .atst           (AWMMUATST),
    .prot           (AWPROT),
    .fixed          (WR_FIXED)
  );
endmodule // untranslated_sideband
`default_nettype wire

/* File: pkg/stream_sideband_defines.vh */
// constants for the untranslated-transaction sideband generator
// assumes inclusion by bare name from design files
`ifndef STREAM_SIDEBAND_DEFINES_VH
`define STREAM_SIDEBAND_DEFINES_VH
`define SB_SID_W        32
`define SB_SSID_W       20
`define SB_PROT_W       3
`define SB_PROT_NS_BIT  1
`define SB_ZERO_SID     32'h00000000
`define SB_ZERO_SSID    20'h00000
`define SB_ZERO_PROT    3'h0
`define SB_PROT_NS_MASK 3'h2
`endif

/* File: rtl/sideband_channel.v */
// one address channel with its untranslated-transaction sideband
// assumes synchronous request inputs and a downstream valid/ready handshake
`default_nettype none
`include "stream_sideband_defines.vh"
module sideband_channel (
  input  wire                    clk,
  input  wire                    resetn,
  input  wire                    ce,
  input  wire                    enable,
  input  wire                    req_valid,
  output wire                    req_ready,
  input  wire                    req_secure,
  input  wire [`SB_SID_W-1:0]    req_sid,
  input  wire                    req_ssid_valid,
  input  wire [`SB_SSID_W-1:0]   req_ssid,
  input  wire                    req_translated,
  input  wire [`SB_PROT_W-1:0]   req_prot,
  output reg                     avalid,
  input  wire                    aready,
  output reg                     secsid,
  output reg  [`SB_SID_W-1:0]    sid,
  output reg                     ssidv,
  output reg  [`SB_SSID_W-1:0]   ssid,
  output reg                     atst,
  output reg  [`SB_PROT_W-1:0]   prot,
  output reg                     fixed
);
  reg                  n_sec;
  reg                  n_ssidv;
  reg [`SB_SSID_W-1:0] n_ssid;
  reg [`SB_PROT_W-1:0] n_prot;
  reg                  n_atst;
  reg                  n_fixed;

  // while ce is high, a new request may load when no request is held or the held one is taken by aready
  assign req_ready = ce && (!avalid || aready);

  always @* begin
    n_atst  = enable & req_translated;
    n_sec   = enable & req_secure & ~n_atst;
    n_ssidv = enable & req_ssid_valid & ~n_atst;
    n_ssid  = n_ssidv ? req_ssid : `SB_ZERO_SSID;
    n_prot  = req_prot;
    if (!n_sec) begin
      n_prot = req_prot | `SB_PROT_NS_MASK;
    end
    // report any request the sanitiser had to alter
    n_fixed = (n_sec != req_secure) || (n_ssidv != req_ssid_valid) ||
              (n_ssid != req_ssid) || (n_prot != req_prot) ||
              (n_atst != req_translated) ||
              (!enable && (req_sid != `SB_ZERO_SID));
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avalid <= 1'b0;
      secsid <= 1'b0;
      sid    <= `SB_ZERO_SID;
      ssidv  <= 1'b0;
      ssid   <= `SB_ZERO_SSID;
      atst   <= 1'b0;
      prot   <= `SB_ZERO_PROT;
      fixed  <= 1'b0;
    end else if (ce) begin
      fixed <= 1'b0;
      if (!avalid || aready) begin
        avalid <= req_valid;
        if (req_valid) begin
          secsid <= n_sec;
          sid    <= enable ? req_sid : `SB_ZERO_SID;
          ssidv  <= n_ssidv;
          ssid   <= n_ssid;
          atst   <= n_atst;
          prot   <= n_prot;
          fixed  <= n_fixed;
        end
      end
    end
  end
endmodule // sideband_channel
`default_nettype wire

/* File: verif/untranslated_sideband_monitor.sv */
// checker for sideband consistency on both address channels
// assumes a bind to untranslated_sideband, one clock domain
`default_nettype none
`include "stream_sideband_defines.vh"
module untranslated_sideband_monitor (
  input wire logic                  CLK_SYS,
  input wire logic                  RESETN,
  input wire logic                  CE,
  input wire logic                  ARVALID,
  input wire logic                  ARREADY,
  input wire logic                  AWVALID,
  input wire logic                  AWREADY,
  input wire logic                  ARMMUSECSID,
  input wire logic                  ARMMUSSIDV,
  input wire logic                  ARMMUATST,
  input wire logic                  AWMMUSECSID,
  input wire logic                  AWMMUSSIDV,
  input wire logic                  AWMMUATST,
  input wire logic [`SB_SID_W-1:0]  ARMMUSID,
  input wire logic [`SB_SID_W-1:0]  AWMMUSID,
  input wire logic [`SB_SSID_W-1:0] ARMMUSSID,
  input wire logic [`SB_SSID_W-1:0] AWMMUSSID,
  input wire logic [`SB_PROT_W-1:0] ARPROT,
  input wire logic [`SB_PROT_W-1:0] AWPROT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  a_rd_ssid_zero: assert property (
    ARVALID && !ARMMUSSIDV |-> ARMMUSSID == 20'h0) else $error("rd ssid");
  a_rd_trans_plain: assert property (
    ARVALID && ARMMUATST |-> !ARMMUSECSID && !ARMMUSSIDV) else $error("rd tr");
  a_rd_prot_ns: assert property (
    ARVALID && !ARMMUSECSID |-> ARPROT[1]) else $error("rd prot");
  a_rd_req_held: assert property (
    ARVALID && !(ARREADY && CE) |=> ARVALID && $stable(ARMMUSSID) &&
      $stable(ARMMUSID))
    else $error("rd dropped");
  a_wr_ssid_zero: assert property (
    AWVALID && !AWMMUSSIDV |-> AWMMUSSID == 20'h0) else $error("wr ssid");
  a_wr_trans_plain: assert property (
    AWVALID && AWMMUATST |-> !(AWMMUSECSID || AWMMUSSIDV)) else $error("wr tr");
  a_wr_prot_ns: assert property (
    AWVALID && !AWMMUSECSID |-> AWPROT[1]) else $error("wr prot");
  a_wr_req_held: assert property (
    $past(AWVALID) && !$past(AWREADY) |-> AWVALID && $stable(AWPROT) &&
      $stable(AWMMUSID))
    else $error("wr dropped");
  cover property (ARVALID && ARMMUATST);
  cover property (AWVALID && !AWREADY);
  cover property (ARVALID && !ARMMUSSIDV);
  cover property (ARVALID && ARMMUSSIDV && ARMMUSSID == 20'h0);
endmodule // untranslated_sideband_monitor
`default_nettype wire

/* File: verif/addr_sink_model.sv */
// address channel receiver that accepts promptly or one cycle in four
// assumes the manager holds its beat until ready is seen
`default_nettype none
module addr_sink_model (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic slow,
  output logic      ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      cnt <= 2'h0;
    else
      cnt <= cnt + 2'h1;
  end
  // slow mode makes the manager hold its request for several cycles
  assign ready = !slow || cnt == 2'h3;
endmodule // addr_sink_model
`default_nettype wire

/* File: verif/tb.sv */
// bench: same request on both channels except inverted write SID, sanitised sideband compared
// assumes two sink models answer the address channels
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rstn = 1'b0, rv = 1'b0, slow = 1'b0;
  logic        ce = 1'b1;
  logic [58:0] q = 59'h0;
  wire logic   rrdy, wrdy, rf, wf, av, wav, ar, aw;
  wire logic [57:0] r, w;
  int          miscompares = 0, cmp_count = 0;
  always #4 clk = ~clk;
  addr_sink_model rd_u (.clk(clk), .resetn(rstn), .slow(slow), .ready(ar));
  addr_sink_model wr_u (.clk(clk), .resetn(rstn), .slow(slow), .ready(aw));
  untranslated_sideband dut_u (.CLK_SYS(clk), .RESETN(rstn), .CE(ce),
    .UT_ENABLE(q[58]), .RD_REQ_VALID(rv), .RD_REQ_READY(rrdy),
    .RD_REQ_SECURE(q[57]), .RD_REQ_SID(q[56:25]), .RD_REQ_SSID_VALID(q[24]),
    .RD_REQ_SSID(q[23:4]), .RD_REQ_TRANSLATED(q[3]), .RD_REQ_PROT(q[2:0]),
    .ARVALID(av), .ARREADY(ar), .ARMMUSECSID(r[57]), .ARMMUSID(r[56:25]),
    .ARMMUSSIDV(r[24]), .ARMMUSSID(r[23:4]), .ARMMUATST(r[3]),
    .ARPROT(r[2:0]), .RD_FIXED(rf), .WR_REQ_VALID(rv), .WR_REQ_READY(wrdy),
    .WR_REQ_SECURE(q[57]), .WR_REQ_SID(~q[56:25]), .WR_REQ_SSID_VALID(q[24]),
    .WR_REQ_SSID(q[23:4]), .WR_REQ_TRANSLATED(q[3]), .WR_REQ_PROT(q[2:0]),
    .AWVALID(wav), .AWREADY(aw), .AWMMUSECSID(w[57]), .AWMMUSID(w[56:25]),
    .AWMMUSSIDV(w[24]), .AWMMUSSID(w[23:4]), .AWMMUATST(w[3]),
    .AWPROT(w[2:0]), .WR_FIXED(wf));
  task automatic chk(input logic [58:0] got, input logic [58:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic go(input logic e, s, v, t, input logic [31:0] i,
                    input logic [19:0] d, input logic [2:0] p);
    logic [57:0] x, wx;
    int n;
    x[3] = t & e;
    x[57] = s & e & !x[3];
    x[24] = v & e & !x[3];
    x[56:25] = e ? i : 32'h0;
    x[23:4] = x[24] ? d : 20'h0;
    x[2:0] = x[57] ? p : p | 3'h2;
    wx = {x[57], e ? ~i : 32'h0, x[24:0]};
    @(posedge clk);
    rv <= 1'b1;
    q <= {e, s, i, v, d, t, p};
    n = 0;
    do @(posedge clk); while ((rrdy !== 1'b1 || wrdy !== 1'b1) && ++n < 50);
    rv <= 1'b0;
    chk(n < 50, 1'b1);
    @(negedge clk);
    chk({av, r}, {1'b1, x});
    chk({wav, w}, {1'b1, wx});
    chk(rf, x != {s, i, v, d, t, p});
    chk(wf, wx != {s, ~i, v, d, t, p});
  endtask
  task t_ce_hold;
    @(posedge clk);
    ce <= 1'b0;
    rv <= 1'b1;
    q <= {1'b1, 1'b0, 32'h0000A5A5, 1'b1, 20'h00000, 1'b0, 3'h0};
    repeat (3) @(posedge clk);
    chk({rrdy, wrdy, av, wav}, 4'h0);
    ce <= 1'b1;
    rv <= 1'b0;
  endtask
  task t_sub_zero;
    go(1'b1, 1'b0, 1'b1, 1'b0, 32'h00000002, 20'h00000, 3'h2);
  endtask
  task t_name_space;
    go(1'b1, 1'b1, 1'b0, 1'b0, 32'h00000042, 20'h00000, 3'h0);
    go(1'b1, 1'b0, 1'b0, 1'b0, 32'h00000042, 20'h00000, 3'h2);
  endtask
  task t_secure_sub;
    go(1'b1, 1'b1, 1'b1, 1'b0, 32'h89ABCDEF, 20'hFFFFF, 3'h0);
  endtask
  task t_no_sub;
    go(1'b1, 1'b0, 1'b0, 1'b0, 32'h00000001, 20'h5A5A5, 3'h0);
  endtask
  task t_translated;
    go(1'b1, 1'b1, 1'b1, 1'b1, 32'hFFFFFFFF, 20'h00001, 3'h5);
  endtask
  task t_disabled;
    go(1'b0, 1'b1, 1'b1, 1'b1, 32'h12345678, 20'h0F0F0, 3'h1);
    go(1'b0, 1'b0, 1'b0, 1'b1, 32'h00000000, 20'h00000, 3'h2);
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    chk({av, r}, 59'h0);
    chk({wav, w}, 59'h0);
    rstn <= 1'b1;
    t_secure_sub;
    t_no_sub;
    t_translated;
    t_disabled;
    t_ce_hold;
    t_sub_zero;
    t_name_space;
    slow <= 1'b1;
    t_no_sub;
    t_secure_sub;
    t_translated;
    stop_test;
  end
  initial begin
    #20000;
    miscompares++;
    stop_test;
  end
endmodule // tb
bind untranslated_sideband untranslated_sideband_monitor mon_u (.CLK_SYS,
  .RESETN, .CE, .ARVALID, .ARREADY, .AWVALID, .AWREADY, .ARMMUSECSID,
  .ARMMUSID, .AWMMUSID,
  .ARMMUSSIDV, .ARMMUATST, .AWMMUSECSID, .AWMMUSSIDV, .AWMMUATST,
  .ARMMUSSID, .AWMMUSSID, .ARPROT, .AWPROT);
`default_nettype wire
